//--- core/tbc_timer.sv
// tbc_timer: 16-bit type-b timer/counter with periodic, timeout-check and
// input-capture modes, reached over AXI4-Lite.
// assumes event_in and companion_tick are synchronous to core_clk.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module tbc_timer
	import tbc_pkg::*;
#(
	parameter int CNT_W   = 16,
	parameter int DIV     = PRESCALE_DIV
)(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        event_in,
	input  wire logic        companion_tick,
	input  wire logic        debug_halt,
	output logic             irq_req,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
			begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic is_capture(input logic [2:0] m);
		return (m == MODE_CAPT_EVT) || (m == MODE_CAPT_FREQ) || (m == MODE_CAPT_PW);
	endfunction : is_capture

	function automatic logic is_mapped(input logic [7:0] a);
		return (a <= REG_CAPTURE_COMPARE_VALUE_HIGH) && (a[1:0] == 2'h0);
	endfunction : is_mapped

	// ****************************************
	// registers
	// ****************************************
	logic             enable_r;
	logic [1:0]       clock_select_field_r;
	logic [2:0]       mode_r;
	logic             capt_en_r;
	logic             edge_r;
	logic             filter_r;
	logic             int_en_r;
	logic             flag_r;
	logic             dbg_cont_r;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] capture_compare_value_r;
	logic [$clog2(DIV)-1:0] presc_r;
	tbc_to_state_t    to_state_r;
	tbc_to_state_t    to_state_nxt;
	logic [CNT_W-1:0] count_nxt;
	logic [CNT_W-1:0] capture_compare_value_nxt;
	logic             flag_set;

	// bus slave state
	logic             awready_r;
	logic             wready_r;
	logic             bvalid_r;
	logic [1:0]       bresp_r;
	logic             arready_r;
	logic             rvalid_r;
	logic [1:0]       rresp_r;
	logic [31:0]      rdata_r;
	logic             aw_hold_r;
	logic             w_hold_r;
	logic [7:0]       waddr_r;
	logic [31:0]      wdata_r;
	logic [3:0]       wstrb_r;
	logic             irq_r;

	tbc_evt_if        evt ();

	// ****************************************
	// bus write path
	// ****************************************
	wire        aw_take   = s_axi_awvalid & awready_r;
	wire        w_take    = s_axi_wvalid & wready_r;
	wire        do_write  = aw_hold_r & w_hold_r;
	wire        aw_hold_n = do_write ? 1'b0 : (aw_hold_r | aw_take);
	wire        w_hold_n  = do_write ? 1'b0 : (w_hold_r | w_take);
	wire        bvalid_n  = do_write | (bvalid_r & ~s_axi_bready);
	wire [31:0] wmerged   = merge(32'h0000_0000, wdata_r, wstrb_r);
	wire        wr_ctrl_a = do_write & (waddr_r == REG_CTRL_A);
	wire        wr_ctrl_b = do_write & (waddr_r == REG_CTRL_B);
	wire        wr_evctrl = do_write & (waddr_r == REG_EVCTRL);
	wire        wr_intctl = do_write & (waddr_r == REG_INTCTRL);
	wire        wr_intflg = do_write & (waddr_r == REG_INTFLAGS);
	wire        wr_dbg    = do_write & (waddr_r == REG_DEBUG_CONTROL_REGISTER);
	wire        wr_count  = do_write & (waddr_r == REG_COUNT);
	wire        wr_capture_compare_value_l = do_write & (waddr_r == REG_CAPTURE_COMPARE_VALUE_LOW) & wstrb_r[0];
	wire        wr_capture_compare_value_h = do_write & (waddr_r == REG_CAPTURE_COMPARE_VALUE_HIGH) & wstrb_r[0];

	// ****************************************
	// bus read path
	// ****************************************
	wire        ar_take   = s_axi_arvalid & arready_r;
	wire        rvalid_n  = ar_take | (rvalid_r & ~s_axi_rready);
	wire        running   = enable_r & ((mode_r != MODE_TIMEOUT) | (to_state_r == TO_RUN));
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (s_axi_araddr)
			REG_CTRL_A:    rd_mux = {29'h0, clock_select_field_r, enable_r};
			REG_CTRL_B:    rd_mux = {29'h0, mode_r};
			REG_EVCTRL:    rd_mux = {25'h0, filter_r, 1'b0, edge_r, 3'h0, capt_en_r};
			REG_INTCTRL:   rd_mux = {31'h0, int_en_r};
			REG_INTFLAGS:  rd_mux = {31'h0, flag_r};
			REG_STATUS:    rd_mux = {31'h0, running};
			REG_DEBUG_CONTROL_REGISTER:   rd_mux = {31'h0, dbg_cont_r};
			REG_COUNT:     rd_mux = {16'h0, count_r};
			REG_CAPTURE_COMPARE_VALUE_LOW:  rd_mux = {24'h0, capture_compare_value_r[7:0]};
			REG_CAPTURE_COMPARE_VALUE_HIGH: rd_mux = {24'h0, capture_compare_value_r[15:8]};
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	wire flag_rd_clr = ar_take & (s_axi_araddr == REG_CAPTURE_COMPARE_VALUE_HIGH) & is_capture(mode_r);
	// status is read-only and count reads have no side effect; reading the capture_compare_value high byte in a capture mode clears the flag
	wire flag_clr    = flag_rd_clr | (wr_intflg & wmerged[INT_CAPT_BIT]);

	// ****************************************
	// tick generation and gating
	// ****************************************
	// debug halt gating
	wire halted = debug_halt & ~dbg_cont_r;
	wire active = enable_r & ~halted;
	wire presc_wrap = (presc_r == ($clog2(DIV))'(DIV - 1));
	wire tick = (clock_select_field_r == CLOCK_SELECT_FIELD_DIV1)      ? 1'b1 :
	            (clock_select_field_r == CLOCK_SELECT_FIELD_DIV2)      ? presc_wrap :
	            (clock_select_field_r == CLOCK_SELECT_FIELD_COMPANION) ? companion_tick : 1'b0;
	wire step = active & tick;

	// ****************************************
	// event edges
	// ****************************************
	assign evt.filter_en = filter_r;

	tbc_event_filter #(
		.SAMPLES (4)
	) u_filter (
		.core_clk (core_clk),
		.rst      (rst),
		.event_in (event_in),
		.ignore   (~active | ~capt_en_r),
		.evt      (evt.src)
	);

	wire sel_edge = edge_r ? evt.fall : evt.rise;

	// ****************************************
	// counter, capture and mode sequencing
	// ****************************************
	// max and top conditions
	wire at_top = (count_r == capture_compare_value_r);
	wire at_max = (count_r == COUNT_MAX);
	wire [CNT_W-1:0] count_inc = step ? (at_max ? COUNT_BOTTOM : count_r + 16'h0001) : count_r;
	wire [31:0]      count_wr  = merge({16'h0, count_r}, wdata_r, wstrb_r);

	always_comb
	begin
		count_nxt    = count_r;
		capture_compare_value_nxt     = capture_compare_value_r;
		flag_set     = 1'b0;
		to_state_nxt = to_state_r;
		unique case (mode_r)
			MODE_PERIODIC:
			begin
				// above top runs on to max and wraps silently
				if (step && at_top)
				begin
					count_nxt = COUNT_BOTTOM;
					flag_set  = 1'b1;
				end
				else
				begin
					count_nxt = count_inc;
				end
			end
			MODE_TIMEOUT:
			begin
				unique case (to_state_r)
					TO_WAIT:
					begin
						count_nxt = count_inc;
						if (sel_edge)
						begin
							count_nxt    = COUNT_BOTTOM;
							to_state_nxt = TO_RUN;
						end
					end
					TO_RUN:
					begin
						count_nxt = count_inc;
						if (step && at_top)
						begin
							flag_set = 1'b1;
						end
						if (sel_edge)
						begin
							count_nxt    = count_r;
							to_state_nxt = TO_FROZEN;
						end
					end
					TO_FROZEN:
					begin
						if (sel_edge)
						begin
							count_nxt    = COUNT_BOTTOM;
							to_state_nxt = TO_RUN;
						end
					end
					default:
					begin
						to_state_nxt = TO_WAIT;
					end
				endcase
			end
			MODE_CAPT_EVT:
			begin
				count_nxt = count_inc;
				if (sel_edge)
				begin
					capture_compare_value_nxt = count_r;
					flag_set = 1'b1;
				end
			end
			MODE_CAPT_FREQ:
			begin
				count_nxt = count_inc;
				if (sel_edge)
				begin
					capture_compare_value_nxt  = count_r;
					count_nxt = COUNT_BOTTOM;
					flag_set  = 1'b1;
				end
			end
			MODE_CAPT_PW:
			begin
				// restart on rise, capture on fall
				count_nxt = count_inc;
				if (evt.rise)
				begin
					count_nxt = COUNT_BOTTOM;
				end
				else if (evt.fall)
				begin
					capture_compare_value_nxt = count_r;
					flag_set = 1'b1;
				end
			end
			default:
			begin
				count_nxt = count_inc;
			end
		endcase
		// software writes win over counting and capture
		if (wr_count)
		begin
			count_nxt = count_wr[CNT_W-1:0];
		end
		if (wr_capture_compare_value_l)
		begin
			capture_compare_value_nxt[7:0] = wdata_r[7:0];
		end
		if (wr_capture_compare_value_h)
		begin
			capture_compare_value_nxt[15:8] = wdata_r[7:0];
		end
		// timeout sequence leaves its state when the mode changes
		if (wr_ctrl_b || !enable_r)
		begin
			to_state_nxt = TO_WAIT;
		end
	end

	// ****************************************
	// control and status flip-flops
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			enable_r   <= 1'b0;
			clock_select_field_r   <= CLOCK_SELECT_FIELD_DIV1;
			mode_r     <= MODE_PERIODIC;
			capt_en_r  <= 1'b0;
			edge_r     <= 1'b0;
			filter_r   <= 1'b0;
			int_en_r   <= 1'b0;
			flag_r     <= 1'b0;
			dbg_cont_r <= 1'b0;
			count_r    <= COUNT_RESET;
			capture_compare_value_r     <= CAPTURE_COMPARE_VALUE_RESET;
			presc_r    <= '0;
			to_state_r <= TO_WAIT;
			irq_r      <= 1'b0;
		end
		else
		begin
			if (wr_ctrl_a)
			begin
				enable_r <= wmerged[CTRL_A_ENABLE_BIT];
				clock_select_field_r <= wmerged[CTRL_A_CLOCK_SELECT_FIELD_LSB +: 2];
			end
			if (wr_ctrl_b)
			begin
				mode_r <= wmerged[2:0];
			end
			if (wr_evctrl)
			begin
				capt_en_r <= wmerged[EVCTRL_CAPT_EN_BIT];
				edge_r    <= wmerged[EVCTRL_EDGE_BIT];
				filter_r  <= wmerged[EVCTRL_FILTER_BIT];
			end
			if (wr_intctl)
			begin
				int_en_r <= wmerged[INT_CAPT_BIT];
			end
			if (wr_dbg)
			begin
				dbg_cont_r <= wmerged[DBG_CONTINUE_BIT];
			end
			// a new event in the clearing cycle keeps the flag set
			flag_r     <= flag_set | (flag_r & ~flag_clr);
			count_r    <= count_nxt;
			capture_compare_value_r     <= capture_compare_value_nxt;
			presc_r    <= (active & ~presc_wrap) ? presc_r + 1'b1 : '0;
			to_state_r <= to_state_nxt;
			irq_r      <= (flag_set | (flag_r & ~flag_clr)) & (wr_intctl ? wmerged[INT_CAPT_BIT] : int_en_r);
		end
	end

	// ****************************************
	// bus slave flip-flops
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			waddr_r   <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OKAY;
			rdata_r   <= 32'h0000_0000;
		end
		else
		begin
			aw_hold_r <= aw_hold_n;
			w_hold_r  <= w_hold_n;
			awready_r <= ~aw_hold_n & ~bvalid_n;
			wready_r  <= ~w_hold_n & ~bvalid_n;
			bvalid_r  <= bvalid_n;
			arready_r <= ~rvalid_n;
			rvalid_r  <= rvalid_n;
			if (aw_take)
			begin
				waddr_r <= s_axi_awaddr;
			end
			if (w_take)
			begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write)
			begin
				bresp_r <= is_mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
			end
			if (ar_take)
			begin
				rdata_r <= rd_mux;
				rresp_r <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	assign irq_req       = irq_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

endmodule : tbc_timer

//--- include/tbc_pkg.sv
// tbc_pkg: register map, field positions, reset values and mode codes of the
// type-b capture timer.
// assumes a 32-bit AXI4-Lite register bus; every register is one aligned word.
package tbc_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] REG_CTRL_A    = 8'h00;
	localparam logic [7:0] REG_CTRL_B    = 8'h04;
	localparam logic [7:0] REG_EVCTRL    = 8'h08;
	localparam logic [7:0] REG_INTCTRL   = 8'h0C;
	localparam logic [7:0] REG_INTFLAGS  = 8'h10;
	localparam logic [7:0] REG_STATUS    = 8'h14;
	localparam logic [7:0] REG_DEBUG_CONTROL_REGISTER   = 8'h18;
	localparam logic [7:0] REG_COUNT     = 8'h1C;
	localparam logic [7:0] REG_CAPTURE_COMPARE_VALUE_LOW  = 8'h20;
	localparam logic [7:0] REG_CAPTURE_COMPARE_VALUE_HIGH = 8'h24;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_A_ENABLE_BIT  = 0;
	localparam int CTRL_A_CLOCK_SELECT_FIELD_LSB  = 1;
	localparam int EVCTRL_CAPT_EN_BIT = 0;
	localparam int EVCTRL_EDGE_BIT    = 4;
	localparam int EVCTRL_FILTER_BIT  = 6;
	localparam int INT_CAPT_BIT       = 0;
	localparam int STATUS_RUN_BIT     = 0;
	localparam int DBG_CONTINUE_BIT   = 0;

	// ****************************************
	// encodings and reset values
	// ****************************************
	localparam logic [1:0] CLOCK_SELECT_FIELD_DIV1      = 2'h0;
	localparam logic [1:0] CLOCK_SELECT_FIELD_DIV2      = 2'h1;
	localparam logic [1:0] CLOCK_SELECT_FIELD_COMPANION = 2'h2;

	localparam logic [2:0] MODE_PERIODIC  = 3'h0;
	localparam logic [2:0] MODE_TIMEOUT   = 3'h1;
	localparam logic [2:0] MODE_CAPT_EVT  = 3'h2;
	localparam logic [2:0] MODE_CAPT_FREQ = 3'h3;
	localparam logic [2:0] MODE_CAPT_PW   = 3'h4;

	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] CAPTURE_COMPARE_VALUE_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
	localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
	localparam int          PRESCALE_DIV = 2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// timeout-check sequence
	typedef enum logic [2:0] {
		TO_WAIT   = 3'b001,
		TO_RUN    = 3'b010,
		TO_FROZEN = 3'b100
	} tbc_to_state_t;

endpackage : tbc_pkg

//--- include/tbc_evt_if.sv
// tbc_evt_if: filtered event edges passed from the input conditioner to the
// timer core.
// assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface tbc_evt_if;
	logic filter_en;
	logic rise;
	logic fall;

	modport src (
		input  filter_en,
		output rise,
		output fall
	);
	modport dst (
		output filter_en,
		input  rise,
		input  fall
	);
endinterface : tbc_evt_if

//--- core/tbc_event_filter.sv
// tbc_event_filter: optional four-sample noise canceler and edge detector on the
// event input.
// assumes event_in is synchronous to core_clk; runs on every core_clk edge.
`timescale 1ns/1ps
module tbc_event_filter
	import tbc_pkg::*;
#(
	parameter int SAMPLES = 4
)(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic event_in,
	input  wire logic ignore,
	tbc_evt_if.src    evt
);

	logic [SAMPLES-1:0] hist_r;
	logic               level_r;
	logic               prev_r;
	logic               rise_r;
	logic               fall_r;
	logic               level_nxt;
	wire                all_high = &hist_r;
	wire                all_low  = ~|hist_r;

	// ****************************************
	// sample history and stable level
	// ****************************************
	// undivided clock sampling
	// the history shifts on every system clock, never on the prescaled tick
	// four agreeing samples
	assign level_nxt = !evt.filter_en ? event_in :
	                   (all_high ? 1'b1 : (all_low ? 1'b0 : level_r));

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			hist_r  <= '0;
			level_r <= 1'b0;
			prev_r  <= 1'b0;
			rise_r  <= 1'b0;
			fall_r  <= 1'b0;
		end
		else
		begin
			hist_r  <= {hist_r[SAMPLES-2:0], event_in};
			level_r <= level_nxt;
			prev_r  <= level_r;
			// edges seen while ignored are dropped, not queued
			rise_r  <= level_r & ~prev_r & ~ignore;
			fall_r  <= ~level_r & prev_r & ~ignore;
		end
	end

	assign evt.rise = rise_r;
	assign evt.fall = fall_r;

endmodule : tbc_event_filter

//--- tb/tbc_timer_properties.sv
// tbc_timer_properties: port-level checks of the type-b timer's bus answers and interrupt line.
// assumes one core_clk domain with synchronous active-high rst.
`timescale 1ns/1ps
module tbc_timer_checker
	import tbc_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        irq_req,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ****************************************
	// properties
	// ****************************************
	property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_rd_one; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rd_one: assert property (p_rd_one) else $error("read answer repeated");
	property p_b_one; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_one: assert property (p_b_one) else $error("write answer repeated");
	property p_wr_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_b_ready_low; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_b_ready_low: assert property (p_b_ready_low) else $error("write taken while answer pending");
	property p_unmapped; s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_CAPTURE_COMPARE_VALUE_HIGH
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_capture_compare_value_hi; s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_CAPTURE_COMPARE_VALUE_HIGH
		|=> s_axi_rdata[31:8] == 24'h0; endproperty
	a_capture_compare_value_hi: assert property (p_capture_compare_value_hi) else $error("capture high byte too wide");
	property p_irq_reset; $fell(rst) |-> !irq_req; endproperty
	a_irq_reset: assert property (p_irq_reset) else $error("interrupt up after reset");
	c_rd: cover property (s_axi_arvalid && s_axi_arready);
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_irq: cover property ($rose(irq_req));
endmodule : tbc_timer_checker
bind tbc_timer tbc_timer_checker u_chk (.core_clk, .rst, .irq_req, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

//--- tb/tbc_evt_src.sv
// tbc_evt_src: stand-in for the event routing network and the companion timer tick.
// assumes go is a one-cycle request on core_clk.
`timescale 1ns/1ps
module tbc_evt_src #(
	parameter int PER = 3
)(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [3:0] len,
	output logic            event_in,
	output logic            companion_tick
);
	logic [3:0] left_r;
	int         div_r;
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			left_r <= 4'h0;
			div_r  <= 0;
		end
		else
		begin
			div_r <= (div_r == PER - 1) ? 0 : div_r + 1;
			// pulse held two cycles or more
			if (go)
				left_r <= (len < 4'h2) ? 4'h2 : len;
			else if (left_r != 4'h0)
				left_r <= left_r - 4'h1;
		end
	end
	assign event_in       = (left_r != 4'h0);
	assign companion_tick = (div_r == PER - 1);
endmodule : tbc_evt_src

//--- tb/testbench.sv
// testbench: self-checking bench of the type-b timer over AXI4-Lite.
// assumes tbc_evt_src supplies events and the companion tick.
`timescale 1ns/1ps
module testbench;
	import tbc_pkg::*;
	logic        core_clk, rst, debug_halt, go, event_in, companion_tick, irq_req;
	logic [3:0]  len, s_axi_wstrb;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed_r, v0, v1, lo, hi;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp, wresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          failures, checked, top, ln;
	int          dv[3] = '{1, PRESCALE_DIV, 3};
	logic [2:0]  md[3] = '{MODE_CAPT_EVT, MODE_CAPT_FREQ, MODE_CAPT_PW};
	tbc_timer #(.DIV(PRESCALE_DIV)) dut (.core_clk, .rst, .event_in, .companion_tick, .debug_halt, .irq_req,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	tbc_evt_src #(.PER(3)) src (.core_clk, .rst, .go, .len, .event_in, .companion_tick);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] in_rng(input logic [31:0] v, input int l, input int h);
		return {31'h0, (int'(v) >= l) && (int'(v) <= h)};
	endfunction : in_rng
	// capture window: pulse width near the pulse length, else near the count seen before the edge
	function automatic logic [31:0] cap_ok(input int k, input logic [31:0] c0, c1, cap, input int l);
		if (k == 2)
			return in_rng(cap, l - 2, l + 2);
		if (k == 1 && c1 >= cap)
			return 32'h0;
		return in_rng(cap, c0, c0 + 14);
	endfunction : cap_ok
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		wresp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 40)
			failures++;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 40)
			failures++;
	endtask : rd
	task automatic fire(input logic [3:0] l);
		@(posedge core_clk);
		go  <= 1'b1;
		len <= l;
		@(posedge core_clk);
		go  <= 1'b0;
	endtask : fire
	task automatic cfg(input logic [2:0] m, input logic [31:0] ev, input logic [1:0] cs);
		wr(REG_CTRL_A, 32'h0);
		wr(REG_CTRL_B, {29'h0, m});
		wr(REG_COUNT, 32'h0);
		wr(REG_EVCTRL, ev);
		wr(REG_INTFLAGS, 32'h1);
		wr(REG_INTCTRL, 32'h1);
		wr(REG_CTRL_A, {29'h0, cs, 1'b1});
	endtask : cfg
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_req !== 1'b1 && n < 100)
		begin
			@(posedge core_clk);
			n++;
		end
	endtask : wait_irq
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (20000) @(posedge core_clk);
		failures++;
		summarize();
	end
	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		{rst, debug_halt, go, len, s_axi_wstrb} = {3'b100, 4'h0, 4'hF};
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{failures, checked, seed_r} = {32'h0, 32'h0, 32'hE2D2};
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rd(REG_CTRL_B, v0, resp);
		chk(v0[2:0], MODE_PERIODIC);
		rd(REG_COUNT, v0, resp);
		chk(v0, 32'h0);
		rd(8'h30, v0, resp);
		chk(resp, RESP_SLVERR);
		wr(8'h30, 32'h1);
		chk(wresp, RESP_SLVERR);
		$display("test reset done");
		wr(REG_CAPTURE_COMPARE_VALUE_LOW, 32'hFF);
		chk(wresp, RESP_OKAY);
		wr(REG_CAPTURE_COMPARE_VALUE_HIGH, 32'hFF);
		for (int k = 0; k < 3; k++)
		begin
			cfg(MODE_PERIODIC, 32'h0, k[1:0]);
			repeat (60) @(posedge core_clk);
			wr(REG_CTRL_A, 32'h0);
			rd(REG_COUNT, v0, resp);
			chk(in_rng(v0, 60 / dv[k], 72 / dv[k] + 1), 32'h1);
		end
		$display("test clock select done");
		cfg(MODE_PERIODIC, 32'h0, CLOCK_SELECT_FIELD_DIV1);
		debug_halt <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			wr(REG_DEBUG_CONTROL_REGISTER, k);
			rd(REG_COUNT, v0, resp);
			repeat (10) @(posedge core_clk);
			rd(REG_COUNT, v1, resp);
			chk((v1 === v0) ? 32'h0 : 32'h1, k);
		end
		debug_halt <= 1'b0;
		wr(REG_DEBUG_CONTROL_REGISTER, 32'h0);
		$display("test debug halt done");
		seed_r = lfsr(seed_r);
		top = 8 + seed_r[2:0];
		wr(REG_CAPTURE_COMPARE_VALUE_LOW, top);
		wr(REG_CAPTURE_COMPARE_VALUE_HIGH, 32'h0);
		cfg(MODE_PERIODIC, 32'h0, CLOCK_SELECT_FIELD_DIV1);
		wait_irq();
		chk(irq_req, 32'h1);
		rd(REG_COUNT, v0, resp);
		chk(in_rng(v0, 0, top), 32'h1);
		wr(REG_INTCTRL, 32'h0);
		repeat (2) @(posedge core_clk);
		chk(irq_req, 32'h0);
		wr(REG_COUNT, 32'hFFF0);
		wr(REG_INTFLAGS, 32'h1);
		repeat (12) @(posedge core_clk);
		rd(REG_INTFLAGS, v0, resp);
		chk(v0, 32'h0);
		rd(REG_COUNT, v0, resp);
		chk(in_rng(v0, 0, top), 32'h1);
		$display("test periodic done");
		wr(REG_CAPTURE_COMPARE_VALUE_LOW, 32'd20);
		cfg(MODE_TIMEOUT, 32'h1, CLOCK_SELECT_FIELD_DIV1);
		fire(4'h3);
		wait_irq();
		chk(irq_req, 32'h1);
		fire(4'h3);
		repeat (6) @(posedge core_clk);
		rd(REG_COUNT, v0, resp);
		repeat (8) @(posedge core_clk);
		rd(REG_COUNT, v1, resp);
		chk(v1, v0);
		fire(4'h3);
		repeat (8) @(posedge core_clk);
		rd(REG_COUNT, v1, resp);
		chk((v1 !== v0) ? 32'h1 : 32'h0, 32'h1);
		$display("test timeout done");
		for (int k = 0; k < 3; k++)
		begin
			cfg(md[k], 32'h1, CLOCK_SELECT_FIELD_DIV1);
			seed_r = lfsr(seed_r);
			repeat (30 + seed_r[3:0]) @(posedge core_clk);
			ln = 4 + seed_r[6:4];
			rd(REG_COUNT, v0, resp);
			fire(ln[3:0]);
			repeat (ln + 8) @(posedge core_clk);
			chk(irq_req, 32'h1);
			rd(REG_COUNT, v1, resp);
			rd(REG_CAPTURE_COMPARE_VALUE_LOW, lo, resp);
			rd(REG_CAPTURE_COMPARE_VALUE_HIGH, hi, resp);
			repeat (3) @(posedge core_clk);
			chk(irq_req, 32'h0);
			chk(cap_ok(k, v0, v1, {16'h0, hi[7:0], lo[7:0]}, ln), 32'h1);
		end
		$display("test capture done");
		cfg(MODE_CAPT_EVT, 32'h41, CLOCK_SELECT_FIELD_DIV2);
		fire(4'h2);
		repeat (14) @(posedge core_clk);
		chk(irq_req, 32'h0);
		fire(4'h6);
		repeat (5) @(posedge core_clk);
		chk(irq_req, 32'h0);
		repeat (9) @(posedge core_clk);
		chk(irq_req, 32'h1);
		$display("test filter done");
		summarize();
	end
endmodule : testbench
